// [rsp_pkg.sv]
// Package and contact driver for the remote signal profile logic
`timescale 1ns/10ps
`default_nettype none
package rsp_pkg;
  localparam logic [4:0] OFF_CTRL = 5'h00;
  localparam logic [4:0] OFF_SER232 = 5'h04;
  localparam logic [4:0] OFF_SER485 = 5'h08;
  localparam logic [4:0] OFF_SPEED = 5'h0c;
  localparam logic [4:0] OFF_STATUS = 5'h10;
  localparam logic [4:0] OFF_IRQ_STAT = 5'h14;
  localparam logic [4:0] OFF_IRQ_MASK = 5'h18;
  // Control register fields
  localparam int CTRL_ALARM_PROF = 0;
  localparam int CTRL_REMOTE_PROF = 1;
  localparam int CTRL_STOP_SCOPE = 2;
  localparam int CTRL_CAUTION = 3;
  // Serial register fields
  localparam int SER_BAUD_LSB = 0;
  localparam int SER_BAUD_W = 17;
  localparam int SER_REPORT = 20;
  localparam int SER_SHARED = 21;
  localparam int SER_NODE_LSB = 24;
  localparam int SER_NODE_W = 8;
  // Speed register fields
  localparam int SPD_UNIT = 0;
  localparam int SPD_REDUCED = 1;
  localparam int SPD_SET_LSB = 16;
  localparam int SPD_SET_W = 11;
  // Interrupt bits
  localparam int IRQ_ALARM = 0;
  localparam int IRQ_WARN = 1;
  localparam int IRQ_STOP = 2;
  localparam int IRQ_PFB = 3;
  localparam int IRQ_W = 4;
  // Reset values
  localparam logic PROF_LEGACY = 1'b0;
  localparam logic PROF_SEMI = 1'b1;
  localparam logic SCOPE_REMOTE_ONLY = 1'b0;
  localparam logic SCOPE_REMOTE_SERIAL = 1'b1;
  localparam logic [16:0] BAUD_DEFAULT = 17'h02580;
  localparam logic [7:0] NODE_DEFAULT = 8'h01;
  localparam logic [10:0] SETPOINT_DEFAULT = 11'h3e8;
  localparam logic [10:0] SETPOINT_MAX = 11'h3e8;
  localparam logic UNIT_PERCENT = 1'b0;
  localparam logic SPEED_NORMAL = 1'b0;
  localparam logic CONTACT_RESET = 1'b0;
  typedef enum logic {RSP_LEGACY_T0, RSP_SEMI_T1} rsp_dummy_t;
endpackage : rsp_pkg

////////////////////////////////////////////////////////////////////////
// One status contact: primary contact level from profile, power and fault
module rsp_contact (
  input wire logic clk,
  input wire logic rst,
  input wire logic semi_profile,
  input wire logic power_on,
  input wire logic fault,
  output logic closed
);
  logic next_closed;

  // Legacy opens on fault; SEMI closes on fault or with power off
  always_comb begin
    if (semi_profile)
      next_closed = fault | ~power_on;
    else
      next_closed = ~fault;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst)
      closed <= rsp_pkg::CONTACT_RESET;
    else
      closed <= next_closed;
  end
endmodule : rsp_contact
`default_nettype wire

// [rsp_top.sv]
// Remote signal profile logic: contacts, stop gating and settings
`timescale 1ns/10ps
`default_nettype none

// Functional notes
// - Legacy profile drops remote-available during power-failure braking.
// - SEMI profile holds remote-available whenever remote operation is available.
// - Remote-only scope honours an open stop input only while remote is available.
// - Remote-and-serial scope also honours an open stop during serial operation.
// - Legacy alarm contact opens on alarm and closes with power off and no fault.
// - SEMI alarm contact closes on power off or alarm and opens with no fault.
// - Legacy warning contact opens on warning and closes with power off and no fault.
// - SEMI warning contact closes on power off or warning and opens with no fault.
// - Defaults are legacy alarm and remote profiles with remote-only stop scope.
// - Default RS-232C link is 9600 bit/s with event reporting on.
// - Default RS-485 link is 9600 bit/s, no shared_bus_addressing, node 01, reporting on.
// - Default speed shows percent, normal speed, reduced setpoint 100.0 percent.
// - Default caution display is enabled.
module rsp_top (
  input wire logic clk,
  input wire logic rst,
  input wire logic [4:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  input wire logic power_on,
  input wire logic alarm_active,
  input wire logic warning_active,
  input wire logic remote_available,
  input wire logic pf_braking,
  input wire logic serial_operation,
  input wire logic stop_open,
  output logic alarm_contact,
  output logic warning_contact,
  output logic remote_contact,
  output logic stop_request,
  output logic caution_display_enable,
  output logic irq
);
  ////////////////////////////////////////////////////////////////////
  // Settings
  logic alarm_semi;
  logic remote_semi;
  logic stop_scope_remote_and_serial;
  logic [16:0] baud232;
  logic [16:0] baud485;
  logic report232;
  logic unsolicited_report_enable;
  logic shared_bus_addressing;
  logic [7:0] node_identifier;
  logic unit_sel;
  logic reduced_sel;
  logic [10:0] reduced_speed_setpoint;
  logic [rsp_pkg::IRQ_W-1:0] irq_stat;
  logic [rsp_pkg::IRQ_W-1:0] irq_mask;
  logic [rsp_pkg::IRQ_W-1:0] event_hit;
  logic ack;
  logic wr_en;
  logic [31:0] next_readdata;
  logic alarm_q;
  logic warn_q;
  logic pfb_q;
  logic next_stop;
  logic next_remote;

  // Address match, shared by read and write decode
  function automatic logic hit(input logic [4:0] a, input logic [4:0] off);
    hit = (a == off);
  endfunction : hit

  ////////////////////////////////////////////////////////////////////
  // Avalon slave: one wait cycle, write lands on the accepting edge
  assign waitrequest = (read | write) & ~ack;
  assign wr_en = write & ack;

  always_ff @(posedge clk or posedge rst) begin
    if (rst)
      ack <= 1'b0;
    else
      ack <= (read | write) & ~ack;
  end

  always_comb begin
    next_readdata = 32'h00000000;
    if (hit(address, rsp_pkg::OFF_CTRL)) begin
      next_readdata[rsp_pkg::CTRL_ALARM_PROF] = alarm_semi;
      next_readdata[rsp_pkg::CTRL_REMOTE_PROF] = remote_semi;
      next_readdata[rsp_pkg::CTRL_STOP_SCOPE] = stop_scope_remote_and_serial;
      next_readdata[rsp_pkg::CTRL_CAUTION] = caution_display_enable;
    end else if (hit(address, rsp_pkg::OFF_SER232)) begin
      next_readdata[rsp_pkg::SER_BAUD_LSB +: rsp_pkg::SER_BAUD_W] = baud232;
      next_readdata[rsp_pkg::SER_REPORT] = report232;
    end else if (hit(address, rsp_pkg::OFF_SER485)) begin
      next_readdata[rsp_pkg::SER_BAUD_LSB +: rsp_pkg::SER_BAUD_W] = baud485;
      next_readdata[rsp_pkg::SER_REPORT] = unsolicited_report_enable;
      next_readdata[rsp_pkg::SER_SHARED] = shared_bus_addressing;
      next_readdata[rsp_pkg::SER_NODE_LSB +: rsp_pkg::SER_NODE_W] = node_identifier;
    end else if (hit(address, rsp_pkg::OFF_SPEED)) begin
      next_readdata[rsp_pkg::SPD_UNIT] = unit_sel;
      next_readdata[rsp_pkg::SPD_REDUCED] = reduced_sel;
      next_readdata[rsp_pkg::SPD_SET_LSB +: rsp_pkg::SPD_SET_W] = reduced_speed_setpoint;
    end else if (hit(address, rsp_pkg::OFF_STATUS)) begin
      next_readdata[6:0] = {stop_open, remote_available, pf_braking, stop_request,
                            remote_contact, warning_contact, alarm_contact};
    end else if (hit(address, rsp_pkg::OFF_IRQ_STAT)) begin
      next_readdata[rsp_pkg::IRQ_W-1:0] = irq_stat;
    end else if (hit(address, rsp_pkg::OFF_IRQ_MASK)) begin
      next_readdata[rsp_pkg::IRQ_W-1:0] = irq_mask;
    end
  end

  // Captured in the wait cycle so data stand at the accepting edge
  always_ff @(posedge clk or posedge rst) begin
    if (rst)
      readdata <= 32'h00000000;
    else if (read & ~ack)
      readdata <= next_readdata;
  end

  ////////////////////////////////////////////////////////////////////
  // Profile and stop scope settings
  // legacy defaults
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      alarm_semi <= rsp_pkg::PROF_LEGACY;
      remote_semi <= rsp_pkg::PROF_LEGACY;
      stop_scope_remote_and_serial <= rsp_pkg::SCOPE_REMOTE_ONLY;
    end else if (wr_en && hit(address, rsp_pkg::OFF_CTRL)) begin
      alarm_semi <= writedata[rsp_pkg::CTRL_ALARM_PROF];
      remote_semi <= writedata[rsp_pkg::CTRL_REMOTE_PROF];
      stop_scope_remote_and_serial <= writedata[rsp_pkg::CTRL_STOP_SCOPE];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst)
      caution_display_enable <= 1'b1;
    else if (wr_en && hit(address, rsp_pkg::OFF_CTRL))
      caution_display_enable <= writedata[rsp_pkg::CTRL_CAUTION];
  end

  ////////////////////////////////////////////////////////////////////
  // Serial link defaults
  // RS-232C defaults
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      baud232 <= rsp_pkg::BAUD_DEFAULT;
      report232 <= 1'b1;
    end else if (wr_en && hit(address, rsp_pkg::OFF_SER232)) begin
      baud232 <= writedata[rsp_pkg::SER_BAUD_LSB +: rsp_pkg::SER_BAUD_W];
      report232 <= writedata[rsp_pkg::SER_REPORT];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      baud485 <= rsp_pkg::BAUD_DEFAULT;
      unsolicited_report_enable <= 1'b1;
      shared_bus_addressing <= 1'b0;
      node_identifier <= rsp_pkg::NODE_DEFAULT;
    end else if (wr_en && hit(address, rsp_pkg::OFF_SER485)) begin
      baud485 <= writedata[rsp_pkg::SER_BAUD_LSB +: rsp_pkg::SER_BAUD_W];
      unsolicited_report_enable <= writedata[rsp_pkg::SER_REPORT];
      shared_bus_addressing <= writedata[rsp_pkg::SER_SHARED];
      node_identifier <= writedata[rsp_pkg::SER_NODE_LSB +: rsp_pkg::SER_NODE_W];
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Variable speed
  // speed defaults
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      unit_sel <= rsp_pkg::UNIT_PERCENT;
      reduced_sel <= rsp_pkg::SPEED_NORMAL;
      reduced_speed_setpoint <= rsp_pkg::SETPOINT_DEFAULT;
    end else if (wr_en && hit(address, rsp_pkg::OFF_SPEED)) begin
      unit_sel <= writedata[rsp_pkg::SPD_UNIT];
      reduced_sel <= writedata[rsp_pkg::SPD_REDUCED];
      // Setpoint above 100.0 percent is clamped, not wrapped
      if (writedata[rsp_pkg::SPD_SET_LSB +: rsp_pkg::SPD_SET_W] > rsp_pkg::SETPOINT_MAX)
        reduced_speed_setpoint <= rsp_pkg::SETPOINT_MAX;
      else
        reduced_speed_setpoint <= writedata[rsp_pkg::SPD_SET_LSB +: rsp_pkg::SPD_SET_W];
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Status contacts
  // alarm contact
  rsp_contact u_alarm (
    .clk(clk),
    .rst(rst),
    .semi_profile(alarm_semi),
    .power_on(power_on),
    .fault(alarm_active),
    .closed(alarm_contact)
  );

  rsp_contact u_warn (
    .clk(clk),
    .rst(rst),
    .semi_profile(alarm_semi),
    .power_on(power_on),
    .fault(warning_active),
    .closed(warning_contact)
  );

  always_comb begin
    if (remote_semi)
      next_remote = remote_available;
    else
      next_remote = remote_available & ~pf_braking;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst)
      remote_contact <= 1'b0;
    else
      remote_contact <= next_remote;
  end

  ////////////////////////////////////////////////////////////////////
  // Hard-wired stop
  // stop scope gate
  always_comb begin
    next_stop = stop_open & (remote_available |
                (stop_scope_remote_and_serial & serial_operation));
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst)
      stop_request <= 1'b0;
    else
      stop_request <= next_stop;
  end

  ////////////////////////////////////////////////////////////////////
  // Interrupts: rising edges of alarm, warning, stop, braking
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      alarm_q <= 1'b0;
      warn_q <= 1'b0;
      pfb_q <= 1'b0;
    end else begin
      alarm_q <= alarm_active;
      warn_q <= warning_active;
      pfb_q <= pf_braking;
    end
  end

  assign event_hit[rsp_pkg::IRQ_ALARM] = alarm_active & ~alarm_q;
  assign event_hit[rsp_pkg::IRQ_WARN] = warning_active & ~warn_q;
  assign event_hit[rsp_pkg::IRQ_STOP] = next_stop & ~stop_request;
  assign event_hit[rsp_pkg::IRQ_PFB] = pf_braking & ~pfb_q;

  // Set beats a same-cycle write-one clear
  genvar gi;
  generate
    for (gi = 0; gi < rsp_pkg::IRQ_W; gi++) begin : g_irq
      always_ff @(posedge clk or posedge rst) begin
        if (rst)
          irq_stat[gi] <= 1'b0;
        else if (event_hit[gi])
          irq_stat[gi] <= 1'b1;
        else if (wr_en && hit(address, rsp_pkg::OFF_IRQ_STAT) && writedata[gi])
          irq_stat[gi] <= 1'b0;
      end
    end
  endgenerate

  always_ff @(posedge clk or posedge rst) begin
    if (rst)
      irq_mask <= '0;
    else if (wr_en && hit(address, rsp_pkg::OFF_IRQ_MASK))
      irq_mask <= writedata[rsp_pkg::IRQ_W-1:0];
  end

  assign irq = |(irq_stat & irq_mask);

  ////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_legacy_remote_brake: assert property (
    (!remote_semi && remote_available && pf_braking) |=> !remote_contact)
    else $error("remote contact not dropped in legacy braking");

  a_semi_remote_hold: assert property (
    (remote_semi && remote_available) |=> remote_contact)
    else $error("remote contact not held in SEMI profile");

  a_stop_remote_only: assert property (
    (!stop_scope_remote_and_serial && !remote_available) |=> !stop_request)
    else $error("stop honoured outside remote in remote-only scope");

  a_stop_serial_scope: assert property (
    (stop_scope_remote_and_serial && serial_operation && stop_open) |=> stop_request)
    else $error("stop ignored during serial operation");

  a_alarm_legacy: assert property (
    (!alarm_semi && alarm_active) ##1 (!alarm_semi && alarm_active) |-> !alarm_contact)
    else $error("legacy alarm contact not open on alarm");

  a_alarm_semi: assert property (
    (alarm_semi && !alarm_active && power_on) |=> !alarm_contact)
    else $error("SEMI alarm contact not open with no fault");

  a_warn_legacy: assert property (
    (!alarm_semi && !power_on && !warning_active) |=> warning_contact)
    else $error("legacy warning contact not closed at power off");

  a_warn_semi: assert property (
    (alarm_semi && warning_active) |=> warning_contact)
    else $error("SEMI warning contact not closed on warning");

  a_reset_defaults: assert property (
    $fell(rst) |-> (!alarm_semi && !remote_semi && !stop_scope_remote_and_serial
                   && caution_display_enable && node_identifier == rsp_pkg::NODE_DEFAULT))
    else $error("defaults wrong after reset");

  a_irq_sticky: assert property (
    (irq_stat[rsp_pkg::IRQ_ALARM] && !(wr_en && hit(address, rsp_pkg::OFF_IRQ_STAT)))
      |=> irq_stat[rsp_pkg::IRQ_ALARM])
    else $error("alarm status bit lost without clear");

  a_bus_answer: assert property (
    ($rose(read) || $rose(write)) |-> waitrequest ##1 !waitrequest)
    else $error("bus answer not after one wait cycle");

  c_braking_drop: cover property (remote_available && pf_braking && !remote_semi);
  c_serial_stop: cover property (serial_operation && stop_open && !remote_available);
  c_semi_alarm: cover property (alarm_semi && alarm_active ##1 alarm_contact);
  c_irq_raise: cover property ($rose(irq));
endmodule : rsp_top
`default_nettype wire

// [rsp_ext_equipment.sv]
// External equipment model: drives the hard-wired stop contact
`timescale 1ns/10ps
`default_nettype none
module rsp_ext_equipment (
  input wire logic clk,
  input wire logic rst,
  input wire logic stop_press,
  output logic stop_open
);
  ////////////////////////////////////////////////////////////////////////
  // Contact settles one cycle after the operator asks, like a relay
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      stop_open <= 1'b0;
    end else begin
      stop_open <= stop_press;
    end
  end
endmodule : rsp_ext_equipment
`default_nettype wire

// [test_remote_signal_profile_logic.sv]
// Self-checking testbench for the remote signal profile logic
`timescale 1ns/10ps
`default_nettype none
module test_remote_signal_profile_logic;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [4:0] address = 5'h00;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic [31:0] readdata, q;
  logic waitrequest, stop_open, stop_press = 1'b0;
  logic power_on = 1'b0, alarm_active = 1'b0, warning_active = 1'b0;
  logic remote_available = 1'b0, pf_braking = 1'b0, serial_operation = 1'b0;
  logic alarm_contact, warning_contact, remote_contact, stop_request;
  logic caution_display_enable, irq;
  int error_cnt = 0;
  int samples_checked = 0;
  int cycles = 0;

  always #10 clk = ~clk;

  rsp_top rsp_top_i (.clk(clk), .rst(rst), .address(address), .read(read),
    .write(write), .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest), .power_on(power_on), .alarm_active(alarm_active),
    .warning_active(warning_active), .remote_available(remote_available),
    .pf_braking(pf_braking), .serial_operation(serial_operation),
    .stop_open(stop_open), .alarm_contact(alarm_contact),
    .warning_contact(warning_contact), .remote_contact(remote_contact),
    .stop_request(stop_request), .caution_display_enable(caution_display_enable),
    .irq(irq));

  rsp_ext_equipment rsp_ext_equipment_i (.clk(clk), .rst(rst),
    .stop_press(stop_press), .stop_open(stop_open));

  ////////////////////////////////////////////////////////////////////////
  task automatic final_report();
    $display("checks %0d, errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : final_report

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : check

  // Hold the request until waitrequest is seen low at the accepting edge
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    @(posedge clk);
    read <= !wr;
    write <= wr;
    address <= a;
    writedata <= d;
    // Only the bench timeout ends a wait that never answers
    do @(posedge clk); while (waitrequest !== 1'b0);
    r = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask : bus

  // Contacts are registered, stop passes one extra flop in the partner
  task automatic settle();
    repeat (3) @(posedge clk);
    @(negedge clk);
  endtask : settle

  ////////////////////////////////////////////////////////////////////////
  task automatic t_defaults();
    bus(1'b0, 5'h00, 32'h0, q);
    check(q[2:0], 3'h0);
    check(q[3], 1'b1);
    check(caution_display_enable, 1'b1);
    bus(1'b0, 5'h04, 32'h0, q);
    check(q[16:0], 17'h02580);
    check(q[20], 1'b1);
    bus(1'b0, 5'h08, 32'h0, q);
    check({q[31:24], q[21:20], q[16:0]}, {8'h01, 2'h1, 17'h02580});
    bus(1'b0, 5'h0c, 32'h0, q);
    check({q[26:16], q[1:0]}, {11'h3e8, 2'h0});
    // Setpoint above full speed reads back clamped
    bus(1'b1, 5'h0c, 32'h07ff0003, q);
    bus(1'b0, 5'h0c, 32'h0, q);
    check(q, 32'h03e80003);
    bus(1'b0, 5'h1c, 32'h0, q);
    check(q, 32'h0);
  endtask : t_defaults

  task automatic t_contacts(input logic semi);
    logic p, a, w, av, pf;
    bus(1'b1, 5'h00, {28'h0, 2'h2, semi, semi}, q);
    for (int i = 0; i < 8; i++) begin
      p = i[2];
      a = i[1];
      w = i[0];
      av = i[0] ^ i[2];
      pf = i[1];
      @(posedge clk);
      power_on <= p;
      alarm_active <= a;
      warning_active <= w;
      remote_available <= av;
      pf_braking <= pf;
      settle();
      check(alarm_contact, semi ? (a | !p) : !a);
      check(warning_contact, semi ? (w | !p) : !w);
      check(remote_contact, semi ? av : (av & !pf));
    end
  endtask : t_contacts

  task automatic t_stop();
    logic av, ser;
    for (int s = 0; s < 2; s++) begin
      bus(1'b1, 5'h00, {28'h0, 1'b1, s[0], 2'h0}, q);
      for (int j = 0; j < 4; j++) begin
        av = j[0];
        ser = j[1];
        @(posedge clk);
        remote_available <= av;
        serial_operation <= ser;
        stop_press <= 1'b1;
        settle();
        check(stop_request, av | (s[0] & ser));
      end
      @(posedge clk);
      stop_press <= 1'b0;
      settle();
      check(stop_request, 1'b0);
    end
  endtask : t_stop

  task automatic t_irq();
    bus(1'b1, 5'h00, 32'h8, q);
    alarm_active <= 1'b0;
    power_on <= 1'b1;
    bus(1'b1, 5'h14, 32'hf, q);
    bus(1'b1, 5'h18, 32'h1, q);
    @(negedge clk);
    check(irq, 1'b0);
    @(posedge clk);
    alarm_active <= 1'b1;
    settle();
    check(irq, 1'b1);
    bus(1'b0, 5'h10, 32'h0, q);
    check(q[0], 1'b0);
    bus(1'b0, 5'h14, 32'h0, q);
    check(q[0], 1'b1);
    bus(1'b1, 5'h14, 32'h1, q);
    @(negedge clk);
    check(irq, 1'b0);
    bus(1'b1, 5'h18, 32'h0, q);
    alarm_active <= 1'b0;
    settle();
    @(posedge clk);
    alarm_active <= 1'b1;
    settle();
    check(irq, 1'b0);
    bus(1'b0, 5'h14, 32'h0, q);
    check(q[0], 1'b1);
  endtask : t_irq

  ////////////////////////////////////////////////////////////////////////
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      error_cnt++;
      final_report();
    end
  end

  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    t_defaults();
    t_contacts(1'b0);
    t_contacts(1'b1);
    t_stop();
    t_irq();
    final_report();
  end
endmodule : test_remote_signal_profile_logic
`default_nettype wire
